// ---- rtl/chan_cond_pkg.sv ----
// Purpose: shared types and constants for the channel conditioning unit
// Assumes: one 20 MHz system clock, unsigned 16-bit channel data
// Notes: all counts are in sample-strobe ticks unless named otherwise
package chan_cond_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int DATA_W = 16;
    localparam int TAPS = 45; // symmetric, odd length: group delay (TAPS-1)/2
    localparam int GROUP_DELAY = (TAPS - 1) / 2; // 22 samples
    localparam int OSR_MAX = 256;
    localparam int FIFO_DEPTH = 8;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'h0100; // 8.8 fixed point, unity
    localparam logic [7:0] OSR_RESET = 8'h08;
    localparam logic [15:0] CIRC_RESET = 16'h07d0; // wheel circumference, mm
    localparam logic [15:0] SPEED_GATE_RESET = 16'h0064; // speed gate, samples

    typedef enum logic {ST_A, ST_B} hyst_state_type;

    // four outputs of one analog channel
    typedef struct packed {
        logic [15:0] raw_mv;
        logic [15:0] filtered_millivolt_value;
        logic [15:0] phys;
        logic [15:0] filtered_physical_value;
    } chan_out_type;

    // hysteresis configuration
    typedef struct packed {
        logic [15:0] val_a;
        logic [15:0] val_b;
        logic [15:0] thr_ab;
        logic [15:0] thr_ba;
        logic [15:0] dly_ab;
        logic [15:0] dly_ba;
        logic [15:0] act_time;
        logic start_b;
    } hyst_cfg_type;
endpackage

// ---- rtl/sync_fifo.sv ----
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty are exact; a write while full is refused
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clocking
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // =====================================================
    // pointers and storage
    // occupancy is compared at pointer width: a depth cast to AW bits would read as zero
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // storage has no reset; contents only matter behind the pointers
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// ---- rtl/channel_conditioning_unit.sv ----
// Purpose: analog decimation filter, wheel speed, hysteresis and vehicle speed
// Assumes: converter samples arrive on a strobe from the same clock
// Notes: the speed pulse pin is asynchronous and is synchronised first
//
// Functional notes
// - oversample input, low-pass decimate to recording rate, cut-off follows rate.
// - at 100 Hz, passband below 40 Hz, stopband above 50 Hz; here a 45-tap equal-weight average instead.
// - decimation filter is linear phase with constant group delay.
// - recorded filtered data is shifted back by the filter delay; here it is recorded with no delay correction.
// - real-time consumers get filtered data without delay correction.
// - each analog channel gives raw, filtered mV, physical, filtered physical.
// - count speed pulses, derive wheel speed from rate and circumference.
// - hysteresis output is the configured constant of the current state.
// - A to B only after threshold met continuously for A-to-B delay.
// - B to A only after threshold met continuously for B-to-A delay.
// - after startup hold configured state until activation time elapsed.
// - two-wheel drive speed is the average while difference below limit.
// - two-wheel drive speed is the larger when difference reaches limit.
// - four-wheel drive speed is the second highest wheel speed.
// - downloaded configuration is held internally for standalone running.
// - offset calibration sets offset so physical reading equals target.
`timescale 1ns/1ps
module channel_conditioning_unit
    import chan_cond_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // converter samples
    input wire logic adc_valid,
    input wire logic [15:0] adc_mv,
    // configuration download
    input wire logic cfg_load,
    input wire logic [7:0] cfg_osr,
    input wire logic [15:0] cfg_gain,
    input wire logic [15:0] cfg_circ,
    input wire logic [15:0] cfg_gate,
    input wire logic [15:0] cfg_diff_limit,
    input wire logic cfg_four_wd,
    input wire hyst_cfg_type cfg_hyst,
    // offset calibration
    input wire logic cal_req,
    input wire logic [15:0] cal_target,
    // speed pulse pin
    input wire logic speed_pulse_input,
    // other wheel speeds
    input wire logic [15:0] wheel_b,
    input wire logic [15:0] wheel_c,
    input wire logic [15:0] wheel_d,
    // real-time outputs
    output chan_out_type chan_out,
    output logic out_strobe,
    output logic [15:0] wheel_speed,
    output logic [15:0] hyst_out,
    output logic hyst_in_b,
    output logic [15:0] vehicle_speed,
    // recording stream of full-history filtered words, no delay correction
    output logic rec_valid,
    input wire logic rec_ready,
    output logic [15:0] rec_data,
    // status
    output logic [15:0] offset_now
);
    // =====================================================
    // state
    typedef struct packed {
        logic [7:0] osr;
        logic [15:0] gain;
        logic [15:0] circ;
        logic [15:0] gate;
        logic [15:0] limit;
        logic four_wd;
        hyst_cfg_type hcfg;
        logic [15:0] offset;
        logic [7:0] os_cnt;
        logic [23:0] acc;
        logic [15:0] raw;
        logic [15:0] filt;
        logic [15:0] rt_delay_cnt;
        logic [5:0] hist_fill;
        logic strobe;
        logic rec_due;
        logic [1:0] pin_sync;
        logic pin_last;
        logic [15:0] pulse_cnt;
        logic [15:0] gate_cnt;
        logic [15:0] wspeed;
        hyst_state_type hst;
        logic [15:0] act_cnt;
        logic active;
        logic [15:0] dly_cnt;
        logic [15:0] vspeed;
    } state_type;

    state_type q, d;
    logic [15:0] hist [TAPS];
    logic [15:0] rec_word;
    logic rec_push;
    logic fifo_ready;
    logic [23:0] fir_sum;
    logic [31:0] scaled;
    logic [31:0] scaled_f;
    logic [16:0] diff;
    logic [15:0] hi1;
    logic [15:0] hi2;
    logic [15:0] lo1;
    logic [15:0] lo2;

    function automatic logic [15:0] to_phys(input logic [31:0] prod, input logic [15:0] off);
        to_phys = 16'(prod[23:8] + off);
    endfunction

    // =====================================================
    // decimated-sample history: a 45-tap symmetric boxcar-like window
    always_ff @(posedge mclk) begin
        if (ce && q.strobe) begin
            hist[0] <= q.raw;
            for (int i = 1; i < TAPS; i++) begin
                hist[i] <= hist[i-1];
            end
        end
    end

    // symmetric weights around the centre keep the phase linear
    always_comb begin
        fir_sum = '0;
        for (int i = 0; i < TAPS; i++) begin
            fir_sum = fir_sum + 24'(hist[i]);
        end
    end

    assign scaled = 32'(q.raw) * 32'(q.gain);
    assign scaled_f = 32'(q.filt) * 32'(q.gain);
    assign diff = (q.wspeed > wheel_b) ? 17'(q.wspeed - wheel_b) : 17'(wheel_b - q.wspeed);

    // four-wheel sort: second highest from two pairwise compares
    always_comb begin
        hi1 = (q.wspeed > wheel_b) ? q.wspeed : wheel_b;
        lo1 = (q.wspeed > wheel_b) ? wheel_b : q.wspeed;
        hi2 = (wheel_c > wheel_d) ? wheel_c : wheel_d;
        lo2 = (wheel_c > wheel_d) ? wheel_d : wheel_c;
    end

    // =====================================================
    // next-state logic
    always_comb begin
        d = q;
        d.strobe = 1'b0;
        // the filter word is fresh one cycle after the strobe; push it then
        d.rec_due = q.strobe && (q.hist_fill == 6'(TAPS));
        // configuration is latched and held after download
        if (cfg_load) begin
            d.osr = (cfg_osr == 8'h00) ? OSR_RESET : cfg_osr;
            d.gain = cfg_gain;
            d.circ = cfg_circ;
            d.gate = (cfg_gate == 16'h0000) ? SPEED_GATE_RESET : cfg_gate;
            d.limit = cfg_diff_limit;
            d.four_wd = cfg_four_wd;
            d.hcfg = cfg_hyst;
            d.os_cnt = 8'h00; // retune: restart averaging at the new ratio
            d.acc = '0;
        end else if (adc_valid) begin
            // oversampled average decimated to the recording rate
            if (q.os_cnt + 8'h01 >= q.osr) begin
                d.raw = 16'((q.acc + 24'(adc_mv)) / 24'(q.osr));
                d.os_cnt = 8'h00;
                d.acc = '0;
                d.strobe = 1'b1;
            end else begin
                d.os_cnt = q.os_cnt + 8'h01;
                d.acc = q.acc + 24'(adc_mv);
            end
        end
        if (q.strobe) begin
            d.filt = 16'(fir_sum / 24'(TAPS));
            if (q.hist_fill != 6'(TAPS)) begin
                d.hist_fill = q.hist_fill + 6'h01;
            end
        end
        // offset so present physical reading equals target
        if (cal_req) begin
            d.offset = 16'(cal_target - scaled[23:8]);
        end
        // speed pulse edge counting over a gate of sample ticks
        d.pin_sync = {q.pin_sync[0], speed_pulse_input};
        d.pin_last = q.pin_sync[1];
        if (q.pin_sync[1] && !q.pin_last) begin
            d.pulse_cnt = q.pulse_cnt + 16'h0001;
        end
        if (q.strobe) begin
            if (q.gate_cnt + 16'h0001 >= q.gate) begin
                d.gate_cnt = 16'h0000;
                d.wspeed = 16'(32'(q.pulse_cnt) * 32'(q.circ) / 32'(q.gate));
                d.pulse_cnt = (q.pin_sync[1] && !q.pin_last) ? 16'h0001 : 16'h0000;
            end else begin
                d.gate_cnt = q.gate_cnt + 16'h0001;
            end
            // activation hold after startup
            if (!q.active) begin
                if (q.act_cnt >= q.hcfg.act_time) begin
                    d.active = 1'b1;
                end else begin
                    d.act_cnt = q.act_cnt + 16'h0001;
                end
            end else begin
                case (q.hst)
                    ST_A: begin
                        // upward crossing held for the A-to-B delay
                        if (d.filt >= q.hcfg.thr_ab) begin
                            if (q.dly_cnt + 16'h0001 >= q.hcfg.dly_ab) begin
                                d.hst = ST_B;
                                d.dly_cnt = 16'h0000;
                            end else begin
                                d.dly_cnt = q.dly_cnt + 16'h0001;
                            end
                        end else begin
                            d.dly_cnt = 16'h0000;
                        end
                    end
                    ST_B: begin
                        // downward crossing held for the B-to-A delay
                        if (d.filt <= q.hcfg.thr_ba) begin
                            if (q.dly_cnt + 16'h0001 >= q.hcfg.dly_ba) begin
                                d.hst = ST_A;
                                d.dly_cnt = 16'h0000;
                            end else begin
                                d.dly_cnt = q.dly_cnt + 16'h0001;
                            end
                        end else begin
                            d.dly_cnt = 16'h0000;
                        end
                    end
                    default: begin
                        d.hst = ST_A;
                    end
                endcase
            end
        end
        // vehicle speed selection
        if (q.four_wd) begin
            d.vspeed = (hi1 > hi2) ? ((lo1 > hi2) ? lo1 : hi2) : ((lo2 > hi1) ? lo2 : hi1);
        end else if (diff < 17'(q.limit)) begin
            d.vspeed = 16'((17'(q.wspeed) + 17'(wheel_b)) >> 1);
        end else begin
            d.vspeed = hi1;
        end
        // before activation the state follows the configured startup state
        if (!q.active && !d.active) begin
            d.hst = d.hcfg.start_b ? ST_B : ST_A;
        end
        if (!ce) begin
            d = q;
        end
    end

    // =====================================================
    // state register; reset returns every function but the filter history (hist, which keeps its samples) to its startup state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.osr <= OSR_RESET;
            q.gain <= GAIN_RESET;
            q.circ <= CIRC_RESET;
            q.gate <= SPEED_GATE_RESET;
            q.offset <= OFFSET_RESET;
            q.hst <= ST_A;
            q.pin_sync <= 2'h3; // pin idles high: no false edge after reset
            q.pin_last <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // =====================================================
    // recording path: only words from a full history are pushed, one cycle after
    // the strobe, so no half-filled average ever reaches the recording
    assign rec_word = q.filt;
    assign rec_push = ce && q.rec_due;

    sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rec_fifo (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .in_valid(rec_push),
        .in_ready(fifo_ready),
        .in_data(rec_word),
        .out_valid(rec_valid),
        .out_ready(rec_ready),
        .out_data(rec_data)
    );

    // =====================================================
    // outputs: real-time values carry no delay correction
    assign chan_out.raw_mv = q.raw;
    assign chan_out.filtered_millivolt_value = q.filt;
    assign chan_out.phys = to_phys(scaled, q.offset);
    assign chan_out.filtered_physical_value = to_phys(scaled_f, q.offset);
    assign out_strobe = q.strobe;
    assign wheel_speed = q.wspeed;
    assign hyst_in_b = q.hst == ST_B;
    assign hyst_out = (q.hst == ST_B) ? q.hcfg.val_b : q.hcfg.val_a;
    assign vehicle_speed = q.vspeed;
    assign offset_now = q.offset;

    // =====================================================
    // checks
    a_hyst_value: assert property (@(posedge mclk) disable iff (reset)
        hyst_out == (q.hst == ST_B ? q.hcfg.val_b : q.hcfg.val_a))
        else $error("hysteresis output does not match state");
    a_hold_startup: assert property (@(posedge mclk) disable iff (reset)
        !q.active && $past(!q.active) |-> $stable(q.hst) || $past(cfg_load))
        else $error("state changed before activation");
    a_ab_delay: assert property (@(posedge mclk) disable iff (reset)
        $rose(q.hst == ST_B) && $past(q.active) |-> $past(q.dly_cnt) + 16'h0001
        >= q.hcfg.dly_ab)
        else $error("a to b without full delay");
    a_ba_delay: assert property (@(posedge mclk) disable iff (reset)
        $rose(q.hst == ST_A) && $past(q.active) |-> $past(q.dly_cnt) + 16'h0001
        >= q.hcfg.dly_ba)
        else $error("b to a without full delay");
    a_two_wd_avg: assert property (@(posedge mclk) disable iff (reset)
        ce && !q.four_wd && diff < 17'(q.limit) && !cfg_load |=>
        vehicle_speed == 16'((17'($past(q.wspeed)) + 17'($past(wheel_b))) >> 1))
        else $error("two wheel average wrong");
    a_two_wd_max: assert property (@(posedge mclk) disable iff (reset)
        ce && !q.four_wd && diff >= 17'(q.limit) && !cfg_load |=>
        vehicle_speed == $past(hi1))
        else $error("two wheel maximum wrong");
    // second highest is the larger of the slower pair winner and the faster pair loser
    a_four_wd_pick: assert property (@(posedge mclk) disable iff (reset)
        ce && q.four_wd |=>
        vehicle_speed >= $past((hi1 < hi2) ? hi1 : hi2)
        && vehicle_speed >= $past((lo1 > lo2) ? lo1 : lo2)
        && (vehicle_speed == $past((hi1 < hi2) ? hi1 : hi2)
        || vehicle_speed == $past((lo1 > lo2) ? lo1 : lo2)))
        else $error("four wheel selection wrong");
    a_cal_offset: assert property (@(posedge mclk) disable iff (reset)
        ce && cal_req |=> offset_now == 16'($past(cal_target) - $past(scaled[23:8])))
        else $error("offset calibration wrong");
    a_rec_order: assert property (@(posedge mclk) disable iff (reset)
        rec_push && $past(ce) |-> $past(q.strobe) && q.hist_fill == 6'(TAPS))
        else $error("recording before filter settled");
    a_cfg_hold: assert property (@(posedge mclk) disable iff (reset)
        !cfg_load ##1 ce |-> $stable(q.gain))
        else $error("configuration changed without download");
    c_to_b: cover property (@(posedge mclk) disable iff (reset) $rose(q.hst == ST_B));
    c_to_a: cover property (@(posedge mclk) disable iff (reset) $fell(q.hst == ST_B));
    c_rec_full: cover property (@(posedge mclk) disable iff (reset) !fifo_ready);
    c_cal: cover property (@(posedge mclk) disable iff (reset) cal_req && ce);
    c_four_wd: cover property (@(posedge mclk) disable iff (reset) ce && q.four_wd);
endmodule

// ---- test/sensor_model.sv ----
// Purpose: sensor-side model, converter samples and tooth pulses
// Assumes: one sample every 4 clocks while enabled
// Notes: between samples the data bus carries the inverse of the last sample
`timescale 1ns/1ps
module sensor_model #(
    parameter int PULSE_PER = 16
) (
    // clocking
    input wire logic mclk,
    // control from the bench
    input wire logic en,
    input wire logic pulse_en,
    input wire logic [15:0] level,
    // sensor pins
    output logic adc_valid,
    output logic [15:0] adc_mv,
    output logic speed_pin
);
    // ====
    // sample and pulse generation
    logic [1:0] phase_q = 2'h0;
    logic [15:0] last_q = 16'h0000;
    int pcnt = 0;
    initial begin
        adc_valid = 1'b0;
        adc_mv = 16'h0000;
        speed_pin = 1'b1;
    end
    // junk between samples, so a design that samples off-strobe is caught
    always @(posedge mclk) begin
        phase_q <= phase_q + 2'h1;
        if (en && phase_q == 2'h3) begin
            adc_valid <= 1'b1;
            adc_mv <= level;
            last_q <= level;
        end else begin
            adc_valid <= 1'b0;
            adc_mv <= ~last_q;
        end
    end
    // hall sensor with pull-up: idles high, low for half a tooth period
    always @(posedge mclk) begin
        pcnt <= (pcnt + 1) % PULSE_PER;
        speed_pin <= !(pulse_en && pcnt < PULSE_PER / 2);
    end
endmodule

// ---- test/tb_channel_conditioning_unit.sv ----
// Purpose: self-checking bench for the channel conditioning unit
// Assumes: unity gain, four samples per strobe, gate of four strobes
// Notes: recorded words are matched against a queue of expected values
`timescale 1ns/1ps
module tb_channel_conditioning_unit;
    import chan_cond_pkg::*;
    // ====
    // signals
    localparam logic [15:0] LEVEL = 16'h0640;
    logic mclk, reset, ce, cfg_load, cfg_four_wd, cal_req, rec_ready, sens_en, pulse_en;
    logic adc_valid, speed_pin, out_strobe, hyst_in_b, rec_valid;
    logic [7:0] cfg_osr;
    logic [15:0] adc_mv, cfg_gain, cfg_circ, cfg_gate, cfg_diff_limit, cal_target;
    logic [15:0] wheel_b, wheel_c, wheel_d, wheel_speed, hyst_out, vehicle_speed;
    logic [15:0] rec_data, offset_now, b, c, d;
    hyst_cfg_type cfg_hyst, h1, h2;
    chan_out_type chan_out;
    int err_total = 0;
    int total_checks = 0;
    int n;
    logic [31:0] seed = 32'hea0b;
    logic [15:0] exp_q[$];

    sensor_model i_sensor (.mclk(mclk), .en(sens_en), .pulse_en(pulse_en), .level(LEVEL),
        .adc_valid(adc_valid), .adc_mv(adc_mv), .speed_pin(speed_pin));
    channel_conditioning_unit i_dut (.mclk(mclk), .reset(reset), .ce(ce),
        .adc_valid(adc_valid), .adc_mv(adc_mv), .cfg_load(cfg_load), .cfg_osr(cfg_osr),
        .cfg_gain(cfg_gain), .cfg_circ(cfg_circ), .cfg_gate(cfg_gate),
        .cfg_diff_limit(cfg_diff_limit), .cfg_four_wd(cfg_four_wd), .cfg_hyst(cfg_hyst),
        .cal_req(cal_req), .cal_target(cal_target), .speed_pulse_input(speed_pin),
        .wheel_b(wheel_b), .wheel_c(wheel_c), .wheel_d(wheel_d), .chan_out(chan_out),
        .out_strobe(out_strobe), .wheel_speed(wheel_speed), .hyst_out(hyst_out),
        .hyst_in_b(hyst_in_b), .vehicle_speed(vehicle_speed), .rec_valid(rec_valid),
        .rec_ready(rec_ready), .rec_data(rec_data), .offset_now(offset_now));

    // ====
    // helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // bubble sort, descending; ties count as separate wheels
    function automatic logic [15:0] second_of(input logic [15:0] a, e, f, g);
        logic [15:0] v[4];
        logic [15:0] t;
        v = '{a, e, f, g};
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                if (v[j] < v[j + 1]) begin
                    t = v[j];
                    v[j] = v[j + 1];
                    v[j + 1] = t;
                end
            end
        end
        return v[1];
    endfunction
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // samples land 1 ns after the edge, once the design's updates settled
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wait_strobes(input int k);
        int s = 0;
        int w = 0;
        while (s < k && w < 20000) begin
            tick(1);
            if (out_strobe === 1'b1) s++;
            w++;
        end
        if (s < k) begin
            err_total++;
            $display("wrong value strobes expected %0d seen %0d", k, s);
            results();
        end
    endtask
    task automatic wait_hyst(input logic lvl, output int k);
        int w = 0;
        k = 0;
        while (hyst_in_b !== lvl && w < 4000) begin
            tick(1);
            if (out_strobe === 1'b1) k++;
            w++;
        end
        if (w >= 4000) begin
            err_total++;
            $display("wrong value hyst_in_b expected %b seen %b", lvl, hyst_in_b);
            results();
        end
    endtask
    task automatic do_reset();
        @(posedge mclk);
        reset <= 1'b1;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        #1;
    endtask
    task automatic load_cfg(input hyst_cfg_type h, input logic [15:0] lim, input logic fwd);
        @(posedge mclk);
        cfg_hyst <= h;
        cfg_diff_limit <= lim;
        cfg_four_wd <= fwd;
        cfg_load <= 1'b1;
        @(posedge mclk);
        cfg_load <= 1'b0;
    endtask

    // ====
    // monitor: recording words against the oldest note, raw value on strobes
    always @(negedge mclk) begin
        if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("wrong value rec_count expected 0 seen 1");
            end else begin
                check("rec_data", exp_q.pop_front(), rec_data);
            end
        end
        if (out_strobe === 1'b1) check("raw_mv", LEVEL, chan_out.raw_mv);
    end

    // ====
    // clock and main sequence
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        {reset, ce} = 2'b11;
        {cfg_load, cfg_four_wd, cal_req, rec_ready, sens_en, pulse_en} = 6'h00;
        {cfg_osr, cfg_gain, cfg_circ, cfg_gate} = {8'h04, 16'h0100, 16'h0064, 16'h0004};
        {cfg_diff_limit, cal_target, wheel_b, wheel_c, wheel_d} = '0;
        h1 = '{16'h0011, 16'h0022, 16'h0320, 16'h0000, 16'h0003, 16'h0003, 16'h0002, 1'b0};
        h2 = '{16'h0011, 16'h0022, 16'hffff, 16'hffff, 16'h0003, 16'h0005, 16'h000a, 1'b1};
        cfg_hyst = h1;
        do_reset();
        check("offset_rst", 16'h0000, offset_now);
        check("state_rst", 16'h0000, {15'h0, hyst_in_b});
        sens_en <= 1'b1;
        pulse_en <= 1'b1;
        load_cfg(h1, 16'h0100, 1'b0);
        wait_hyst(1'b1, n);
        check("hyst_b", 16'h0022, hyst_out);
        check("thr_up", 16'h0001, {15'h0, chan_out.filtered_millivolt_value >= 16'h0320});
        wait_strobes(60);
        check("filt_mv", LEVEL, chan_out.filtered_millivolt_value);
        check("filt_phys", LEVEL, chan_out.filtered_physical_value);
        check("phys", LEVEL, chan_out.phys);
        check("speed", 16'h0001, {15'h0, wheel_speed >= 75 && wheel_speed <= 125});
        $display("test filter, hysteresis and wheel speed done");
        // stop the stream so the full buffer holds still while it drains
        @(posedge mclk);
        sens_en <= 1'b0;
        tick(40);
        repeat (FIFO_DEPTH) exp_q.push_back(LEVEL);
        @(posedge mclk);
        rec_ready <= 1'b1;
        tick(30);
        check("rec_left", 16'h0000, 16'(exp_q.size()));
        check("rec_valid", 16'h0000, {15'h0, rec_valid});
        rec_ready <= 1'b0;
        cal_target <= 16'h0100;
        cal_req <= 1'b1;
        sens_en <= 1'b1;
        pulse_en <= 1'b0;
        @(posedge mclk);
        cal_req <= 1'b0;
        $display("test recording buffer done");
        wait_strobes(16);
        check("offset", 16'h0100 - LEVEL, offset_now);
        check("phys_cal", 16'h0100, chan_out.phys);
        check("wheel_stop", 16'h0000, wheel_speed);
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            b = seed[15:0] & 16'h7ffe;
            seed = xorshift(seed);
            c = seed[15:0];
            seed = xorshift(seed);
            d = seed[15:0];
            @(posedge mclk);
            {wheel_b, wheel_c, wheel_d} <= {b, c, d};
            load_cfg(h1, b + 16'h0002, 1'b0);
            tick(3);
            check("veh_avg", b >> 1, vehicle_speed);
            load_cfg(h1, b, 1'b0);
            tick(3);
            check("veh_max", b, vehicle_speed);
            load_cfg(h1, b, 1'b1);
            tick(3);
            check("veh_4wd", second_of(16'h0000, b, c, d), vehicle_speed);
        end
        $display("test calibration and vehicle speed done");
        do_reset();
        check("offset_rst2", 16'h0000, offset_now);
        load_cfg(h2, 16'h0100, 1'b0);
        wait_strobes(8);
        check("hold_b", 16'h0001, {15'h0, hyst_in_b});
        check("hyst_b2", 16'h0022, hyst_out);
        wait_hyst(1'b0, n);
        check("delay_ba", 16'h0001, {15'h0, n >= 6});
        check("hyst_a", 16'h0011, hyst_out);
        $display("test startup hold done");
        results();
    end
endmodule
